// *** src/cgen_cfg_bridge.sv ***
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - One type bit picks type 0 or 1.
// - Type 1 drives whole address register out.
// - Type 0 sets one upper line from device.
// - Type 0 low lines: zeros, function, register, zeros.
// - Suppress bit reports master abort as success.
// - Data access retried first, then cycle starts.
// - Byte enables from low address and size.
// - Retry other data and acknowledge accesses while cycle outstanding.
// - Read data captured; repeat access returns it.
// - Write completes locally after PCI write completes.
// - Register read produces interrupt acknowledge cycle.
// - No lock between the two register sides.
// - Local read gives config read; write, write.
module cgen_cfg_bridge (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [1:0] transfer_size,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    output logic pci_req_valid,
    output cgen_pkg::cgen_pci_req_s pci_req,
    input wire cgen_pkg::cgen_pci_rsp_s pci_rsp
);
    import cgen_pkg::*;

    // ************************************************************
    // Helpers.
    // ************************************************************

    // Byte lanes of a local access, lane 0 at the low byte address.
    function automatic logic [3:0] cgen_be(input logic [1:0] size, input logic [1:0] lo);
        logic [3:0] be;
        be = 4'hF;
        case (size)
            CGEN_SIZE_BYTE: be = 4'h1 << lo;
            CGEN_SIZE_HALF: be = lo[1] ? 4'hC : 4'h3;
            default: be = 4'hF;
        endcase
        return be;
    endfunction : cgen_be

    // Word index of a register offset.
    function automatic logic [9:0] cgen_word(input logic [11:0] addr);
        return addr[11:2];
    endfunction : cgen_word

    // ************************************************************
    // Declarations.
    // ************************************************************
    cgen_state_e state_ff, nxt_state;
    cgen_act_e act_ff, nxt_act;
    cgen_kind_e tr_kind_ff, nxt_tr_kind;
    logic pready_ff, nxt_pready;
    logic pslverr_ff, nxt_pslverr;
    logic [31:0] prdata_ff, nxt_prdata;
    logic [31:0] cfg_addr_ff, nxt_cfg_addr;
    logic [1:0] misc_ff, nxt_misc;
    logic [31:0] data_ff, nxt_data;
    logic [31:0] iack_ff, nxt_iack;
    logic [11:0] tr_addr_ff, nxt_tr_addr;
    logic [1:0] tr_size_ff, nxt_tr_size;
    logic mabort_ff, nxt_mabort;
    logic retry_ff, nxt_retry;
    logic req_valid_ff, nxt_req_valid;
    cgen_pci_req_s req_ff, nxt_req;
    logic setup;
    logic access_done;
    logic is_data;
    logic is_iack;
    logic is_delayed;
    cgen_kind_e acc_kind;
    logic match;
    logic [31:0] ad_phase;
    logic [31:0] status;

    // ************************************************************
    // Address phase.
    // ************************************************************

    // The encoder only looks at the stored address and type bit.
    cgen_addr_phase u_addr_phase (
        .cfg_addr(cfg_addr_ff),
        .cfg_type(misc_ff[CGEN_MISC_TYPE_BIT]),
        .ad_phase(ad_phase)
    );

    // ************************************************************
    // Access decode.
    // ************************************************************

    // Classify the request and compare it with the parked transaction.
    always_comb begin
        setup = psel && !penable;
        access_done = psel && penable && pready_ff;
        is_data = cgen_word(paddr) == cgen_word(CGEN_OFF_CFG_DATA);
        is_iack = (cgen_word(paddr) == cgen_word(CGEN_OFF_IACK)) && !pwrite;
        is_delayed = is_data || is_iack;
        if (is_iack) begin
            acc_kind = CGEN_KIND_IACK;
        end else if (pwrite) begin
            acc_kind = CGEN_KIND_CFG_WR;
        end else begin
            acc_kind = CGEN_KIND_CFG_RD;
        end
        // The repeat must carry the same address, size and direction.
        match = (state_ff == CGEN_ST_HOLD) && (tr_kind_ff == acc_kind) &&
            (tr_addr_ff == paddr) && (tr_size_ff == transfer_size);
        status = 32'h0000_0000;
        status[CGEN_STAT_BUSY_BIT] = state_ff == CGEN_ST_RUN;
        status[CGEN_STAT_READY_BIT] = state_ff == CGEN_ST_HOLD;
        status[CGEN_STAT_MABORT_BIT] = mabort_ff;
        status[CGEN_STAT_RETRY_BIT] = retry_ff;
    end

    // ************************************************************
    // Bus answer.
    // ************************************************************

    // Decide the answer in the setup cycle; it shows in the first access cycle.
    always_comb begin
        nxt_pready = 1'b0;
        nxt_pslverr = 1'b0;
        nxt_prdata = 32'h0000_0000;
        nxt_act = act_ff;
        if (setup) begin
            nxt_pready = 1'b1;
            nxt_act = CGEN_ACT_REG;
            if (is_delayed) begin
                case (state_ff)
                    CGEN_ST_IDLE: begin
                        nxt_act = CGEN_ACT_START;
                        nxt_pslverr = 1'b1;
                    end
                    CGEN_ST_HOLD: begin
                        if (match) begin
                            nxt_act = CGEN_ACT_DONE;
                            // Suppression hides the abort from a host bridge.
                            nxt_pslverr = mabort_ff &&
                                !misc_ff[CGEN_MISC_MA_SUPPRESS_BIT];
                            if (!pwrite) begin
                                nxt_prdata = is_iack ? iack_ff : data_ff;
                            end
                        end else begin
                            nxt_act = CGEN_ACT_RETRY;
                            nxt_pslverr = 1'b1;
                        end
                    end
                    default: begin
                        nxt_act = CGEN_ACT_RETRY;
                        nxt_pslverr = 1'b1;
                    end
                endcase
            end else if (!pwrite) begin
                if (cgen_word(paddr) == cgen_word(CGEN_OFF_CFG_ADDR)) begin
                    nxt_prdata = cfg_addr_ff;
                end else if (cgen_word(paddr) == cgen_word(CGEN_OFF_MISC)) begin
                    nxt_prdata = {30'h0000_0000, misc_ff};
                end else if (cgen_word(paddr) == cgen_word(CGEN_OFF_STATUS)) begin
                    nxt_prdata = status;
                end else begin
                    nxt_pslverr = 1'b1;
                end
            end else if (cgen_word(paddr) > cgen_word(CGEN_OFF_STATUS)) begin
                nxt_pslverr = 1'b1;
            end
        end
    end

    // Answer registers; pready is high for exactly one access cycle.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
            act_ff <= CGEN_ACT_REG;
        end else begin
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff <= nxt_prdata;
            act_ff <= nxt_act;
        end
    end

    // ************************************************************
    // Registers and delayed transaction.
    // ************************************************************

    // Everything changes only at the completing access edge or on PCI done.
    always_comb begin
        nxt_state = state_ff;
        nxt_cfg_addr = cfg_addr_ff;
        nxt_misc = misc_ff;
        nxt_data = data_ff;
        nxt_iack = iack_ff;
        nxt_tr_kind = tr_kind_ff;
        nxt_tr_addr = tr_addr_ff;
        nxt_tr_size = tr_size_ff;
        nxt_mabort = mabort_ff;
        nxt_retry = retry_ff;
        nxt_req_valid = req_valid_ff;
        nxt_req = req_ff;
        if (access_done) begin
            case (act_ff)
                CGEN_ACT_START: begin
                    nxt_state = CGEN_ST_RUN;
                    nxt_tr_kind = acc_kind;
                    nxt_tr_addr = paddr;
                    nxt_tr_size = transfer_size;
                    nxt_mabort = 1'b0;
                    nxt_retry = 1'b1;
                    nxt_req_valid = 1'b1;
                    nxt_req.be = cgen_be(transfer_size, paddr[1:0]);
                    nxt_req.wdata = pwdata;
                    if (is_iack) begin
                        nxt_req.cmd = CGEN_CMD_IACK;
                        nxt_req.addr = {20'h0_0000, paddr};
                    end else begin
                        nxt_req.cmd = pwrite ? CGEN_CMD_CFG_WR : CGEN_CMD_CFG_RD;
                        nxt_req.addr = ad_phase;
                    end
                    if (pwrite) begin
                        nxt_data = pwdata;
                    end
                end
                CGEN_ACT_DONE: begin
                    nxt_state = CGEN_ST_IDLE;
                    nxt_retry = 1'b0;
                end
                CGEN_ACT_RETRY: begin
                    nxt_retry = 1'b1;
                end
                default: begin
                    // Plain stores: no lock against the PCI side's own writes.
                    if (pwrite && cgen_word(paddr) == cgen_word(CGEN_OFF_CFG_ADDR)) begin
                        nxt_cfg_addr = pwdata;
                    end
                    if (pwrite && cgen_word(paddr) == cgen_word(CGEN_OFF_MISC)) begin
                        nxt_misc = pwdata[1:0];
                    end
                end
            endcase
        end
        // PCI done cannot meet a start or a completion: those need other states.
        if (state_ff == CGEN_ST_RUN && pci_rsp.done) begin
            nxt_state = CGEN_ST_HOLD;
            nxt_req_valid = 1'b0;
            nxt_mabort = pci_rsp.mabort;
            if (tr_kind_ff == CGEN_KIND_CFG_RD) begin
                nxt_data = pci_rsp.rdata;
            end else if (tr_kind_ff == CGEN_KIND_IACK) begin
                nxt_iack = pci_rsp.rdata;
            end
        end
    end

    // Transaction and register state.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= CGEN_ST_IDLE;
            cfg_addr_ff <= CGEN_CFG_ADDR_RESET;
            misc_ff <= CGEN_MISC_RESET;
            data_ff <= CGEN_DATA_RESET;
            iack_ff <= CGEN_DATA_RESET;
            tr_kind_ff <= CGEN_KIND_CFG_RD;
            tr_addr_ff <= 12'h000;
            tr_size_ff <= CGEN_SIZE_WORD;
            mabort_ff <= 1'b0;
            retry_ff <= 1'b0;
            req_valid_ff <= 1'b0;
            req_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            cfg_addr_ff <= nxt_cfg_addr;
            misc_ff <= nxt_misc;
            data_ff <= nxt_data;
            iack_ff <= nxt_iack;
            tr_kind_ff <= nxt_tr_kind;
            tr_addr_ff <= nxt_tr_addr;
            tr_size_ff <= nxt_tr_size;
            mabort_ff <= nxt_mabort;
            retry_ff <= nxt_retry;
            req_valid_ff <= nxt_req_valid;
            req_ff <= nxt_req;
        end
    end

    // ************************************************************
    // Outputs.
    // ************************************************************

    // All outputs come straight from flip-flops.
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign prdata = prdata_ff;
    assign pci_req_valid = req_valid_ff;
    assign pci_req = req_ff;

endmodule : cgen_cfg_bridge

// *** src/cgen_pkg.sv ***
// ****************************************************************
// Constants and carriers of the configuration cycle generator.
// ****************************************************************
package cgen_pkg;

    // ************************************************************
    // Register bus geometry and register offsets.
    // ************************************************************
    localparam int unsigned CGEN_ADDR_W = 12;
    localparam logic [11:0] CGEN_OFF_CFG_ADDR = 12'h000;
    localparam logic [11:0] CGEN_OFF_CFG_DATA = 12'h004;
    localparam logic [11:0] CGEN_OFF_MISC = 12'h008;
    localparam logic [11:0] CGEN_OFF_IACK = 12'h00C;
    localparam logic [11:0] CGEN_OFF_STATUS = 12'h010;

    // ************************************************************
    // Field positions and reset values.
    // ************************************************************
    localparam int unsigned CGEN_MISC_MA_SUPPRESS_BIT = 0;
    localparam int unsigned CGEN_MISC_TYPE_BIT = 1;
    localparam logic [1:0] CGEN_MISC_RESET = 2'h0;
    localparam logic [31:0] CGEN_CFG_ADDR_RESET = 32'h0000_0000;
    localparam logic [31:0] CGEN_DATA_RESET = 32'h0000_0000;
    localparam int unsigned CGEN_DEV_LSB = 11;
    localparam int unsigned CGEN_DEV_MSB = 14;
    localparam int unsigned CGEN_FUNC_LSB = 8;
    localparam int unsigned CGEN_FUNC_MSB = 10;
    localparam int unsigned CGEN_REG_LSB = 2;
    localparam int unsigned CGEN_REG_MSB = 7;
    localparam int unsigned CGEN_IDSEL_LSB = 16;
    localparam int unsigned CGEN_STAT_BUSY_BIT = 0;
    localparam int unsigned CGEN_STAT_READY_BIT = 1;
    localparam int unsigned CGEN_STAT_MABORT_BIT = 2;
    localparam int unsigned CGEN_STAT_RETRY_BIT = 3;

    // ************************************************************
    // Transfer sizes on the local bus and PCI commands.
    // ************************************************************
    localparam logic [1:0] CGEN_SIZE_WORD = 2'h0;
    localparam logic [1:0] CGEN_SIZE_BYTE = 2'h1;
    localparam logic [1:0] CGEN_SIZE_HALF = 2'h2;
    localparam logic [3:0] CGEN_CMD_IACK = 4'h0;
    localparam logic [3:0] CGEN_CMD_CFG_RD = 4'hA;
    localparam logic [3:0] CGEN_CMD_CFG_WR = 4'hB;

    // ************************************************************
    // Types.
    // ************************************************************
    typedef enum logic [2:0] {
        CGEN_ST_IDLE = 3'b001,
        CGEN_ST_RUN = 3'b010,
        CGEN_ST_HOLD = 3'b100
    } cgen_state_e;

    typedef enum logic [1:0] {
        CGEN_ACT_REG = 2'h0,
        CGEN_ACT_START = 2'h1,
        CGEN_ACT_DONE = 2'h2,
        CGEN_ACT_RETRY = 2'h3
    } cgen_act_e;

    typedef enum logic [1:0] {
        CGEN_KIND_CFG_RD = 2'h0,
        CGEN_KIND_CFG_WR = 2'h1,
        CGEN_KIND_IACK = 2'h2
    } cgen_kind_e;

    typedef struct packed {
        logic [3:0] cmd;
        logic [31:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } cgen_pci_req_s;

    typedef struct packed {
        logic done;
        logic mabort;
        logic [31:0] rdata;
    } cgen_pci_rsp_s;

endpackage : cgen_pkg

// *** src/cgen_addr_phase.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Address phase encoder for configuration cycles.
// ****************************************************************
module cgen_addr_phase (
    input wire logic [31:0] cfg_addr,
    input wire logic cfg_type,
    output logic [31:0] ad_phase
);
    import cgen_pkg::*;

    logic [3:0] device_number_field;
    logic [15:0] idsel;

    // Type 1 passes the whole address; type 0 builds a one-hot select.
    always_comb begin
        device_number_field = cfg_addr[CGEN_DEV_MSB:CGEN_DEV_LSB];
        idsel = 16'h0001 << device_number_field;
        ad_phase = 32'h0000_0000;
        if (cfg_type) begin
            ad_phase = cfg_addr;
        end else begin
            ad_phase[31:CGEN_IDSEL_LSB] = idsel;
            ad_phase[CGEN_FUNC_MSB:CGEN_FUNC_LSB] =
                cfg_addr[CGEN_FUNC_MSB:CGEN_FUNC_LSB];
            ad_phase[CGEN_REG_MSB:CGEN_REG_LSB] =
                cfg_addr[CGEN_REG_MSB:CGEN_REG_LSB];
        end
    end

endmodule : cgen_addr_phase

// *** bench/cgen_monitor.sv ***
`timescale 1ns/1ps
// ************************************************************
// Port checker of the configuration cycle generator.
// ************************************************************
module cgen_monitor (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [1:0] transfer_size,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic pci_req_valid,
    input wire cgen_pkg::cgen_pci_req_s pci_req,
    input wire cgen_pkg::cgen_pci_rsp_s pci_rsp
);
    import cgen_pkg::*;
    logic [31:0] cfg_sh_ff;
    logic [31:0] nxt_cfg_sh;
    logic type_sh_ff;
    logic nxt_type_sh;
    logic wr_ok;
    logic cfg_cyc;
    logic [15:0] sel_exp;
    // Shadow the address word and the type bit as software writes them.
    assign wr_ok = psel && penable && pready && pwrite && !pslverr;
    always_comb begin
        nxt_cfg_sh = (wr_ok && paddr == CGEN_OFF_CFG_ADDR) ? pwdata : cfg_sh_ff;
        nxt_type_sh = (wr_ok && paddr == CGEN_OFF_MISC) ? pwdata[CGEN_MISC_TYPE_BIT] : type_sh_ff;
    end
    // Cleared with the block, so both sides start from the same reset values.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_sh_ff <= CGEN_CFG_ADDR_RESET;
            type_sh_ff <= 1'b0;
        end else begin
            cfg_sh_ff <= nxt_cfg_sh;
            type_sh_ff <= nxt_type_sh;
        end
    end
    // Lane mask expected from the low address bits and the transfer size.
    function automatic logic [3:0] lanes(input logic [1:0] a, input logic [1:0] s);
        if (s == CGEN_SIZE_BYTE) begin
            return 4'h1 << a;
        end
        return (s == CGEN_SIZE_HALF) ? (4'h3 << a) : 4'hF;
    endfunction : lanes
    assign cfg_cyc = pci_req_valid && pci_req.cmd != CGEN_CMD_IACK;
    assign sel_exp = 16'h0001 << cfg_sh_ff[14:11];
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    type_one_addr_a: assert property (
        cfg_cyc && type_sh_ff |-> pci_req.addr == cfg_sh_ff)
        else $error("type 1 address is not the address word");
    dev_select_a: assert property (
        cfg_cyc && !type_sh_ff |-> pci_req.addr[31:16] == sel_exp)
        else $error("device select line wrong");
    low_lines_a: assert property (cfg_cyc && !type_sh_ff |->
        pci_req.addr[15:0] == {5'h00, cfg_sh_ff[10:8], cfg_sh_ff[7:2], 2'h0})
        else $error("type 0 low address lines wrong");
    retry_first_a: assert property (
        $rose(pci_req_valid) |-> $past(pready) && $past(pslverr))
        else $error("cycle started without a retried access");
    busy_retry_a: assert property (psel && penable && pready && pci_req_valid &&
        $past(pci_req_valid) && paddr[11:2] == CGEN_OFF_CFG_DATA[11:2] |-> pslverr)
        else $error("access during an outstanding cycle not retried");
    read_write_a: assert property ($rose(pci_req_valid) &&
        $past(paddr[11:2]) == CGEN_OFF_CFG_DATA[11:2] |->
        pci_req.cmd == ($past(pwrite) ? CGEN_CMD_CFG_WR : CGEN_CMD_CFG_RD))
        else $error("command does not follow access direction");
    iack_cmd_a: assert property ($rose(pci_req_valid) &&
        $past(paddr[11:2]) == CGEN_OFF_IACK[11:2] |-> pci_req.cmd == CGEN_CMD_IACK)
        else $error("acknowledge read gave another command");
    lane_mask_a: assert property ($rose(pci_req_valid) |->
        pci_req.be == lanes($past(paddr[1:0]), $past(transfer_size)))
        else $error("byte enables do not match the access");
endmodule : cgen_monitor

bind cgen_cfg_bridge cgen_monitor u_monitor (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .transfer_size, .pready, .prdata, .pslverr, .pci_req_valid, .pci_req, .pci_rsp);

// *** bench/cgen_pci_model.sv ***
`timescale 1ns/1ps
// ************************************************************
// Far side model answering configuration and acknowledge cycles.
// ************************************************************
module cgen_pci_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic pci_req_valid,
    input wire cgen_pkg::cgen_pci_req_s pci_req,
    input wire logic [3:0] delay,
    input wire logic mabort_mode,
    output cgen_pkg::cgen_pci_rsp_s pci_rsp,
    output logic [7:0] n_done,
    output cgen_pkg::cgen_pci_req_s seen_req
);
    import cgen_pkg::*;
    logic [3:0] cnt_ff;
    logic answered_ff;
    // One answer per request after a set wait; off the answer the data lines toggle.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 4'h0;
            answered_ff <= 1'b0;
            pci_rsp <= '0;
            n_done <= 8'h00;
            seen_req <= '0;
        end else begin
            pci_rsp.done <= 1'b0;
            pci_rsp.rdata <= ~pci_rsp.rdata;
            if (!pci_req_valid) begin
                cnt_ff <= 4'h0;
                answered_ff <= 1'b0;
            end else if (!answered_ff && cnt_ff == delay) begin
                pci_rsp.done <= 1'b1;
                pci_rsp.mabort <= mabort_mode;
                pci_rsp.rdata <= pci_req.addr ^ 32'h5A5A_5A5A;
                answered_ff <= 1'b1;
                n_done <= n_done + 8'h01;
                seen_req <= pci_req;
            end else begin
                cnt_ff <= cnt_ff + 4'h1;
            end
        end
    end
endmodule : cgen_pci_model

// *** bench/pci_config_cycle_generator_tb.sv ***
`timescale 1ns/1ps
// ************************************************************
// Self-checking bench of the configuration cycle generator.
// ************************************************************
module pci_config_cycle_generator_tb;
    import cgen_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n, psel, penable, pwrite, pready, pslverr, pci_req_valid, mab, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, ca, ea;
    logic [1:0] transfer_size;
    logic [3:0] delay;
    logic [7:0] nd;
    cgen_pci_req_s pci_req, seen_req;
    cgen_pci_rsp_s pci_rsp;
    int error_cnt = 0;
    int checks_done = 0;
    logic [1:0] ta [8] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h2, 2'h0, 2'h0};
    logic [1:0] ts [8] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h0, 2'h3};
    logic [3:0] tb [8] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF, 4'hF};
    cgen_cfg_bridge dut (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .transfer_size, .pready, .prdata, .pslverr, .pci_req_valid, .pci_req, .pci_rsp);
    cgen_pci_model u_far (.ref_clk, .rst_n, .pci_req_valid, .pci_req, .delay,
        .mabort_mode(mab), .pci_rsp, .n_done(nd), .seen_req);
    // Free running clock at 40 MHz.
    always #12.5 ref_clk = ~ref_clk;
    // Compare one value and count the result.
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        checks_done++;
        if (g !== x) begin
            $display("[FAIL] %s expected %h seen %h", nm, x, g);
            error_cnt++;
        end
    endtask : chk
    // One APB transfer; the request is held until pready is sampled high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [1:0] s, output logic [31:0] r, output logic er);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        transfer_size <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) chk("pready", 32'h1, 32'h0);
        @(posedge ref_clk);
    endtask : apb
    // Delayed access: retried first, status polled, then repeated with the same request.
    task automatic cyc(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [1:0] s, input logic poke, output logic [31:0] r, output logic er);
        logic [31:0] st;
        logic e0;
        int n;
        apb(w, a, d, s, r, e0);
        chk("first retry", 32'h1, {31'h0, e0});
        if (poke) begin
            apb(w, a, d, s, r, e0);
            chk("busy retry", 32'h1, {31'h0, e0});
        end
        n = 0;
        do begin
            apb(1'b0, CGEN_OFF_STATUS, 32'h0, CGEN_SIZE_WORD, st, e0);
            n++;
        end while (st[CGEN_STAT_READY_BIT] !== 1'b1 && n < 40);
        // A poll limit that runs out counts as a mismatch here.
        chk("result ready", 32'h1, {31'h0, st[CGEN_STAT_READY_BIT]});
        apb(w, a, d, s, r, er);
    endtask : cyc
    // Print the counts and the verdict, then stop.
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize
    // Cuts a hang short; the tests need a few hundred cycles.
    initial begin
        repeat (30000) @(posedge ref_clk);
        error_cnt++;
        summarize();
    end
    // Main sequence.
    initial begin
        {rst_n, psel, penable, pwrite, mab} = '0;
        paddr = 12'h000;
        pwdata = 32'h0;
        transfer_size = 2'h0;
        delay = 4'h2;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        apb(1'b0, CGEN_OFF_CFG_ADDR, 32'h0, CGEN_SIZE_WORD, rd, e);
        chk("addr reset", CGEN_CFG_ADDR_RESET, rd);
        apb(1'b0, CGEN_OFF_MISC, 32'h0, CGEN_SIZE_WORD, rd, e);
        chk("misc reset", 32'h0, rd);
        apb(1'b0, 12'h014, 32'h0, CGEN_SIZE_WORD, rd, e);
        chk("unmapped", 32'h1, {31'h0, e});
        apb(1'b1, CGEN_OFF_IACK, 32'hFFFF_FFFF, CGEN_SIZE_WORD, rd, e);
        chk("iack write", 32'h0, {31'h0, e});
        // Type 0 over every device number, with junk in the ignored bits.
        for (int d = 0; d < 16; d++) begin
            ca = {16'hABCD, 1'b1, 4'(d), 3'(d), 6'(63 - d), 2'h3};
            apb(1'b1, CGEN_OFF_CFG_ADDR, ca, CGEN_SIZE_WORD, rd, e);
            cyc(1'b0, CGEN_OFF_CFG_DATA, 32'h0, CGEN_SIZE_WORD, 1'b0, rd, e);
            ea = (32'h1 << (16 + d)) | {21'h0, 3'(d), 6'(63 - d), 2'h0};
            chk("type 0 addr", ea, seen_req.addr);
            chk("cfg read cmd", {28'h0, CGEN_CMD_CFG_RD}, {28'h0, seen_req.cmd});
            chk("read data", ea ^ 32'h5A5A_5A5A, rd);
        end
        // Type 1 write with a slow far side and a poke while busy.
        apb(1'b1, CGEN_OFF_MISC, 32'h2, CGEN_SIZE_WORD, rd, e);
        apb(1'b1, CGEN_OFF_CFG_ADDR, 32'h8123_4567, CGEN_SIZE_WORD, rd, e);
        delay <= 4'hC;
        cyc(1'b1, CGEN_OFF_CFG_DATA, 32'hCAFE_0001, CGEN_SIZE_WORD, 1'b1, rd, e);
        chk("write done", 32'h0, {31'h0, e});
        chk("one cycle", 32'h11, {24'h0, nd});
        chk("type 1 addr", 32'h8123_4567, seen_req.addr);
        chk("cfg write cmd", {28'h0, CGEN_CMD_CFG_WR}, {28'h0, seen_req.cmd});
        chk("write data", 32'hCAFE_0001, seen_req.wdata);
        delay <= 4'h0;
        // Byte enables for every size, each byte lane and both aligned halfword positions.
        for (int i = 0; i < 8; i++) begin
            cyc(1'b0, CGEN_OFF_CFG_DATA | 12'(ta[i]), 32'h0, ts[i], 1'b0, rd, e);
            chk("byte enables", {28'h0, tb[i]}, {28'h0, seen_req.be});
        end
        // Master abort reported as error, then hidden by the suppress bit.
        mab <= 1'b1;
        cyc(1'b0, CGEN_OFF_CFG_DATA, 32'h0, CGEN_SIZE_WORD, 1'b0, rd, e);
        chk("abort error", 32'h1, {31'h0, e});
        // Only the abort flag may stand once the cycle is finished.
        apb(1'b0, CGEN_OFF_STATUS, 32'h0, CGEN_SIZE_WORD, rd, e);
        chk("abort status", 32'h1 << CGEN_STAT_MABORT_BIT, rd);
        apb(1'b1, CGEN_OFF_MISC, 32'h3, CGEN_SIZE_WORD, rd, e);
        apb(1'b0, CGEN_OFF_MISC, 32'h0, CGEN_SIZE_WORD, rd, e);
        chk("misc readback", 32'h3, rd);
        cyc(1'b0, CGEN_OFF_CFG_DATA, 32'h0, CGEN_SIZE_WORD, 1'b0, rd, e);
        chk("abort hidden", 32'h0, {31'h0, e});
        mab <= 1'b0;
        // Interrupt acknowledge read.
        cyc(1'b0, CGEN_OFF_IACK, 32'h0, CGEN_SIZE_WORD, 1'b0, rd, e);
        chk("iack cmd", {28'h0, CGEN_CMD_IACK}, {28'h0, seen_req.cmd});
        chk("iack data", {20'h0, CGEN_OFF_IACK} ^ 32'h5A5A_5A5A, rd);
        summarize();
    end
endmodule : pci_config_cycle_generator_tb
